// ---- tape_write_command_handler_tb.sv ----
`timescale 1ns/1ps
module tape_write_command_handler_tb;
   import twc_pkg::*;
   // ==========================================================
   // Signals
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cmd_valid = 1'b0;
   logic leave_write = 1'b0;
   logic buf_wr_ready = 1'b1;
   logic tape_byte = 1'b0;
   logic pblk_done = 1'b0;
   logic pblk_ok = 1'b0;
   logic hload = 1'b0;
   logic hslow = 1'b0;
   logic [15:0] hn = 16'h0;
   twc_cdb_type cmd_cdb = '0;
   twc_cfg_type cfg = '0;
   twc_media_type media = '0;
   logic in_valid, in_ready, xfer_active, buf_wr_valid, tape_go, rewrite_req;
   logic disconnect, write_mode, button_enable, status_valid, status_check;
   logic [7:0] in_data, buf_wr_data;
   logic [15:0] n_sent;
   twc_sense_type sense;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_stat = 0;
   int n_rw = 0;
   int s0, r0;
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (status_valid === 1'b1) n_stat <= n_stat + 1;
      if (rewrite_req === 1'b1) n_rw <= n_rw + 1;
   end
   // Host bytes count up from zero, so the buffer side must see them in order
   logic [7:0] exp_b = 8'h00;
   always @(posedge core_clk) begin
      if (buf_wr_valid === 1'b1 && buf_wr_ready === 1'b1) begin
         exp_b <= exp_b + 8'h01;
         chk("data", {16'h0, exp_b}, {16'h0, buf_wr_data});
      end
   end
   twc_write_cmd u_dut (.core_clk(core_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
      .cmd_cdb(cmd_cdb), .cfg(cfg), .media(media), .leave_write(leave_write),
      .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
      .xfer_active(xfer_active), .buf_wr_valid(buf_wr_valid), .buf_wr_data(buf_wr_data),
      .buf_wr_ready(buf_wr_ready), .tape_byte(tape_byte), .pblk_done(pblk_done),
      .pblk_ok(pblk_ok), .tape_go(tape_go), .rewrite_req(rewrite_req),
      .disconnect(disconnect), .write_mode(write_mode), .button_enable(button_enable),
      .status_valid(status_valid), .status_check(status_check), .sense(sense));
   twc_host_model u_host (.core_clk(core_clk), .rst_b(rst_b), .load(hload),
      .load_n(hn), .slow(hslow), .in_ready(in_ready), .xfer_active(xfer_active),
      .in_valid(in_valid), .in_data(in_data), .n_sent(n_sent));
   // ==========================================================
   // Tasks
   function automatic logic [23:0] z(input logic x);
      return {23'h0, x};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   // Flag order: valid eom physical_end_of_tape wp medium retry
   task automatic chk_sense(input logic [3:0] key, input logic [5:0] fl, input logic [5:0] m);
      logic [5:0] got;
      got = {sense.valid, sense.end_of_medium_flag, sense.physical_end_of_tape, sense.wp, sense.med_err, sense.retry_exh};
      chk("check", 24'h1, z(status_check));
      chk("key", {20'h0, key}, {20'h0, sense.key});
      chk("flags", {18'h0, fl & m}, {18'h0, got & m});
   endtask
   task automatic cmd(input logic fx, input logic [23:0] len);
      s0 = n_stat;
      cmd_cdb <= {8'h00, len[7:0], len[15:8], len[23:16], {7'h00, fx}, WRITE_OPCODE};
      cmd_valid <= 1'b1;
      tick(1);
      cmd_valid <= 1'b0;
   endtask
   task automatic wait_stat;
      for (int i = 0; i < 4000 && n_stat == s0; i++) tick(1);
      chk("status", 24'h1, z(n_stat != s0));
   endtask
   task automatic host(input logic [15:0] n, input logic sl);
      hn <= n;
      hslow <= sl;
      hload <= 1'b1;
      tick(1);
      hload <= 1'b0;
   endtask
   task automatic wait_host(input logic [15:0] n);
      for (int i = 0; i < 2000 && n_sent != n; i++) tick(1);
   endtask
   task automatic tapes(input int n);
      repeat (n) begin
         tape_byte <= 1'b1;
         tick(1);
         tape_byte <= 1'b0;
         tick(1);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========================================================
   // Tests
   initial begin
      tick(20000);
      n_mismatch++;
      $display("BAD watchdog exp done got hang");
      print_verdict;
   end
   initial begin
      cfg.buffered = 1'b1;
      cfg.block_size = 24'h4;
      cfg.min_len = 24'h1;
      cfg.max_len = 24'h100;
      cfg.reconn_thr = 24'h100;
      media.pos_ok = 1'b1;
      tick(20);
      rst_b <= 1'b1;
      tick(2);
      chk("btn", 24'h1, z(button_enable));
      chk("wmode", 24'h0, z(write_mode));
      chk("rdy", 24'h1, z(in_ready));
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         media <= '{not_ready: i == 0, protect: i < 2, pos_ok: i != 2, default: 1'b0};
         cfg.no_disc <= (i == 5);
         cfg.max_len <= (i == 5) ? 24'hffffff : 24'h100;
         cmd(i == 3, i == 4 ? 24'h101 : (i == 5 ? 24'h028001 : 24'h10));
         wait_stat;
         chk_sense(i == 0 ? KEY_NOT_READY : (i == 1 ? KEY_PROTECT : KEY_ILLEGAL),
            {3'h0, i == 1, 2'h0}, i == 0 ? 6'h0 : 6'h4);
      end
      cfg.no_disc <= 1'b0;
      cfg.max_len <= 24'h100;
      $display("test refusals done");
      cmd(1'b0, 24'h0);
      wait_stat;
      chk("check", 24'h0, z(status_check));
      chk("wmode", 24'h1, z(write_mode));
      chk("btn", 24'h1, z(button_enable));
      $display("test zero done");
      // Receiver stalls so the two-entry buffer must refuse
      buf_wr_ready <= 1'b0;
      host(16'd6, 1'b0);
      cmd(1'b0, 24'h6);
      tick(12);
      chk("rdy", 24'h0, z(in_ready));
      chk("bufv", 24'h1, z(buf_wr_valid));
      chk("disc", 24'h0, z(disconnect));
      buf_wr_ready <= 1'b1;
      wait_stat;
      chk("sent", 24'h6, {8'h0, n_sent});
      chk("check", 24'h0, z(status_check));
      chk("go", 24'h0, z(tape_go));
      chk("btn", 24'h0, z(button_enable));
      leave_write <= 1'b1;
      tick(1);
      leave_write <= 1'b0;
      tick(2);
      chk("wmode", 24'h0, z(write_mode));
      chk("btn", 24'h0, z(button_enable));
      tapes(6);
      tick(2);
      chk("btn", 24'h1, z(button_enable));
      $display("test buffered done");
      cfg.fixed <= 1'b1;
      cfg.buffered <= 1'b0;
      host(16'd9, 1'b1);
      cmd(1'b1, 24'h2);
      wait_host(16'd8);
      tick(20);
      chk("sent", 24'h8, {8'h0, n_sent});
      chk("early", 24'h0, z(n_stat != s0));
      chk("xfer", 24'h0, z(xfer_active));
      tapes(8);
      wait_stat;
      chk("check", 24'h0, z(status_check));
      host(16'd0, 1'b0);
      $display("test unbuffered done");
      cfg.fixed <= 1'b0;
      cfg.buffered <= 1'b1;
      cfg.motion_thr <= 24'h3;
      host(16'd3, 1'b0);
      cmd(1'b0, 24'h8);
      wait_host(16'd3);
      tick(4);
      chk("go", 24'h1, z(tape_go));
      media.physical_end_of_tape <= 1'b1;
      wait_stat;
      media.physical_end_of_tape <= 1'b0;
      chk_sense(KEY_OVERFLOW, 6'h38, 6'h3f);
      chk("info", 24'h8, sense.info);
      tapes(3);
      cfg.motion_thr <= 24'h0;
      $display("test physical end done");
      host(16'd1, 1'b0);
      cmd(1'b0, 24'h4);
      wait_host(16'd1);
      r0 = n_rw;
      repeat (12) begin
         pblk_done <= 1'b1;
         tick(1);
         pblk_done <= 1'b0;
         tick(1);
      end
      wait_stat;
      chk_sense(KEY_MEDIUM, 6'h23, 6'h3f);
      chk("rewrite", 24'h1, z((n_rw - r0) == 12));
      tapes(1);
      $display("test retry done");
      // Seventeen blocks fail once then pass; the eighteenth first failure stops
      host(16'd1, 1'b0);
      cmd(1'b0, 24'h4);
      wait_host(16'd1);
      for (int i = 0; i < 35; i++) begin
         pblk_ok <= (i % 2 == 1);
         pblk_done <= 1'b1;
         tick(1);
         pblk_done <= 1'b0;
         tick(1);
      end
      wait_stat;
      chk_sense(KEY_MEDIUM, 6'h22, 6'h3f);
      pblk_ok <= 1'b0;
      tapes(1);
      $display("test consecutive done");
      cfg.fixed <= 1'b1;
      cfg.block_size <= 24'h2;
      host(16'd6, 1'b1);
      cmd(1'b1, 24'h3);
      wait_host(16'd1);
      media.logical_end_warning <= 1'b1;
      tick(30);
      chk("sent", 24'h2, {8'h0, n_sent});
      tapes(2);
      wait_stat;
      media.logical_end_warning <= 1'b0;
      chk_sense(KEY_NO_SENSE, 6'h30, 6'h3f);
      chk("info", 24'h2, sense.info);
      host(16'd0, 1'b0);
      $display("test logical end done");
      print_verdict;
   end
endmodule

// ---- twc_fifo.sv ----
`timescale 1ns/1ps
module twc_fifo
   import twc_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic s_valid,
   input wire logic [WIDTH-1:0] s_data,
   output logic s_ready,
   output logic m_valid,
   output logic [WIDTH-1:0] m_data,
   input wire logic m_ready
);

localparam int CW = $clog2(DEPTH + 1);

typedef struct packed {
   logic [DEPTH-1:0][WIDTH-1:0] mem;
   logic [CW-1:0] cnt;
   logic rdy;
   logic vld;
} twc_fifo_state_type;

twc_fifo_state_type f_q, f_d;
logic push;
logic pop;

assign push = s_valid && f_q.rdy;
assign pop = f_q.vld && m_ready;

// Head always sits in entry 0 so the output is a plain flop
always_comb begin
   f_d = f_q;
   if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
         f_d.mem[i] = f_q.mem[i + 1];
      end
   end
   if (push) begin
      f_d.mem[f_q.cnt - CW'(pop)] = s_data;
   end
   f_d.cnt = f_q.cnt + CW'(push) - CW'(pop);
   f_d.rdy = f_d.cnt != CW'(DEPTH);
   f_d.vld = f_d.cnt != '0;
end

always_ff @(posedge core_clk or negedge rst_b) begin
   if (!rst_b) begin
      f_q <= '0;
   end else begin
      f_q <= f_d;
   end
end

assign s_ready = f_q.rdy;
assign m_valid = f_q.vld;
assign m_data = f_q.mem[0];

endmodule

// ---- twc_host_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Host initiator byte source
module twc_host_model
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic [15:0] load_n,
   input wire logic slow,
   input wire logic in_ready,
   input wire logic xfer_active,
   output logic in_valid,
   output logic [7:0] in_data,
   output logic [15:0] n_sent
);
   logic [15:0] rem_q;
   logic [7:0] dat_q;
   logic gap_q;
   logic take;
   assign take = in_valid & in_ready & xfer_active;
   assign in_valid = (rem_q != 16'h0) & ~gap_q;
   // Idle line shows an inverted byte so a stale value never passes
   assign in_data = in_valid ? dat_q : ~dat_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rem_q <= 16'h0;
         dat_q <= 8'h00;
         gap_q <= 1'b0;
         n_sent <= 16'h0;
      end else if (load) begin
         rem_q <= load_n;
         n_sent <= 16'h0;
      end else if (take) begin
         rem_q <= rem_q - 16'h1;
         dat_q <= dat_q + 8'h01;
         n_sent <= n_sent + 16'h1;
         gap_q <= slow;
      end else begin
         gap_q <= 1'b0;
      end
   end
endmodule

// ---- twc_pkg.sv ----
package twc_pkg;
// ==========================================================
// How it works
// - Opcode 0Ah six-byte block starts a write.
// - Byte 1 bit 0 selects fixed mode.
// - Bytes 2-4 count bytes or blocks.
// - Zero length writes nothing, good status.
// - Fixed blocks use configured block size.
// - Buffered data held until motion threshold.
// - Buffered status returned before tape recording.
// - Full buffer disconnects; reconnect at threshold.
// - No-disconnect caps one write at 160 KBytes.
// - Non-buffered good status once tape holds all.
// - Logical end warning forces non-buffered operation.
// - Write mode from write until leaving commands.
// - Button locked in write mode with data.
// - Variable length outside limits: illegal request.
// - Fixed bit against configured mode: illegal request.
// - End warning: finish block, end-of-medium, no sense.
// - Fixed end warning information: blocks unwritten.
// - Variable physical end: flags, overflow when buffered.
// - Fixed physical end: flags, key by buffer.
// - Bad tape position: illegal request.
// - Write protected: data protect, protect flag.
// - Failed read-back rewrites block elsewhere.
// - Twelve failed attempts: medium error, retries exhausted.
// - 18 consecutive failed blocks: medium error.
// - Cartridge not loaded: not ready.

// ==========================================================
// Command block layout
localparam int CDB_OP_BYTE = 0;
localparam int CDB_FLAG_BYTE = 1;
localparam int CDB_LEN_HI = 2;
localparam int CDB_LEN_MID = 3;
localparam int CDB_LEN_LO = 4;
localparam int FIXED_BIT = 0;
localparam logic [7:0] WRITE_OPCODE = 8'h0a;

// ==========================================================
// Sense keys
localparam logic [3:0] KEY_NO_SENSE = 4'h0;
localparam logic [3:0] KEY_NOT_READY = 4'h2;
localparam logic [3:0] KEY_MEDIUM = 4'h3;
localparam logic [3:0] KEY_ILLEGAL = 4'h5;
localparam logic [3:0] KEY_PROTECT = 4'h7;
localparam logic [3:0] KEY_OVERFLOW = 4'hd;

// ==========================================================
// Sizes and limits
localparam logic [23:0] MOTION_THR_DEFAULT = 24'h020000;
localparam logic [47:0] NODISC_MAX_BYTES = 48'h000000028000;
localparam logic [23:0] BUF_CAP_BYTES = 24'h040000;
localparam logic [3:0] RETRY_LIMIT = 4'hc;
localparam logic [4:0] CONSEC_LIMIT = 5'h12;
localparam int FIFO_WIDTH = 8;
localparam int FIFO_DEPTH = 2;

// ==========================================================
// Types
typedef logic [5:0][7:0] twc_cdb_type;

typedef enum logic [1:0] {PH_IDLE, PH_XFER, PH_WAIT, PH_RESP} twc_phase_type;

typedef struct packed {
   logic valid;
   logic end_of_medium_flag;
   logic physical_end_of_tape;
   logic wp;
   logic med_err;
   logic retry_exh;
   logic [3:0] key;
   logic [23:0] info;
} twc_sense_type;

typedef struct packed {
   logic not_ready;
   logic protect;
   logic pos_ok;
   logic logical_end_warning;
   logic physical_end_of_tape;
} twc_media_type;

typedef struct packed {
   logic fixed;
   logic buffered;
   logic no_disc;
   logic [23:0] block_size;
   logic [23:0] min_len;
   logic [23:0] max_len;
   logic [23:0] motion_thr;
   logic [23:0] reconn_thr;
} twc_cfg_type;

typedef struct packed {
   twc_phase_type phase;
   logic fixed;
   logic buffered;
   logic logical_end_warning_hold;
   logic [23:0] len;
   logic [23:0] blk_len;
   logic [23:0] nblk;
   logic [23:0] byte_in_blk;
   logic [23:0] blks_in;
   logic [23:0] byte_tape_blk;
   logic [23:0] blks_tape;
   logic [23:0] level;
   logic drain;
   logic disc;
   logic take_en;
   logic wmode;
   logic btn_en;
   logic [3:0] retry;
   logic [4:0] consec;
   logic rewrite;
   logic stat_v;
   logic check;
   twc_sense_type sense;
} twc_state_type;

localparam twc_state_type STATE_RESET = '{phase: PH_IDLE, btn_en: 1'b1, default: '0};

endpackage

// ---- twc_write_cmd.sv ----
`timescale 1ns/1ps
module twc_write_cmd
   import twc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   input wire twc_cdb_type cmd_cdb,
   input wire twc_cfg_type cfg,
   input wire twc_media_type media,
   input wire logic leave_write,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   output logic in_ready,
   output logic xfer_active,
   output logic buf_wr_valid,
   output logic [7:0] buf_wr_data,
   input wire logic buf_wr_ready,
   input wire logic tape_byte,
   input wire logic pblk_done,
   input wire logic pblk_ok,
   output logic tape_go,
   output logic rewrite_req,
   output logic disconnect,
   output logic write_mode,
   output logic button_enable,
   output logic status_valid,
   output logic status_check,
   output twc_sense_type sense
);

// ==========================================================
// Command decode
twc_state_type s_q, s_d;
logic is_write;
logic fixed_req;
logic [23:0] req_len;
logic [47:0] req_bytes;
logic err_nr;
logic err_wp;
logic err_pos;
logic err_mode;
logic err_lim;
logic err_nd;
logic active;
logic fifo_in_valid;
logic take;
logic fail_ev;
logic retry_out;
logic consec_out;
logic blk_end_in;
logic [23:0] info_diff;
logic [23:0] motion_thr;

assign is_write = cmd_valid && s_q.phase == PH_IDLE
   && cmd_cdb[CDB_OP_BYTE] == WRITE_OPCODE;
assign fixed_req = cmd_cdb[CDB_FLAG_BYTE][FIXED_BIT];
assign req_len = {cmd_cdb[CDB_LEN_HI], cmd_cdb[CDB_LEN_MID], cmd_cdb[CDB_LEN_LO]};
assign req_bytes = fixed_req ? req_len * cfg.block_size : {24'h000000, req_len};

assign err_nr = media.not_ready;
assign err_wp = media.protect;
assign err_pos = !media.pos_ok;
assign err_mode = fixed_req != cfg.fixed;
// Zero length is never a limit violation
assign err_lim = !fixed_req && req_len != 24'h000000
   && (req_len < cfg.min_len || req_len > cfg.max_len);
assign err_nd = cfg.no_disc && req_bytes > NODISC_MAX_BYTES;

assign active = s_q.phase == PH_XFER || s_q.phase == PH_WAIT;
assign fifo_in_valid = in_valid && s_q.take_en;
assign take = fifo_in_valid && in_ready;
assign blk_end_in = take && s_q.byte_in_blk == s_q.blk_len - 24'h000001;

assign fail_ev = pblk_done && !pblk_ok;
assign retry_out = fail_ev && s_q.retry == RETRY_LIMIT - 4'h1;
assign consec_out = fail_ev && s_q.retry == 4'h0
   && s_q.consec == CONSEC_LIMIT - 5'h01;

// Counts only tape progress seen during this command
assign info_diff = s_q.fixed ? s_q.nblk - s_q.blks_tape
   : s_q.len - s_q.byte_tape_blk;
// A zero threshold means software left the default
assign motion_thr = cfg.motion_thr == 24'h000000 ? MOTION_THR_DEFAULT
   : cfg.motion_thr;

// ==========================================================
// Data path buffer
twc_fifo #(
   .WIDTH(FIFO_WIDTH),
   .DEPTH(FIFO_DEPTH)
) u_fifo (
   .core_clk(core_clk),
   .rst_b(rst_b),
   .s_valid(fifo_in_valid),
   .s_data(in_data),
   .s_ready(in_ready),
   .m_valid(buf_wr_valid),
   .m_data(buf_wr_data),
   .m_ready(buf_wr_ready)
);

// ==========================================================
// Next state
always_comb begin
   s_d = s_q;
   s_d.stat_v = 1'b0;
   s_d.rewrite = 1'b0;
   s_d.level = s_q.level + {23'h000000, take} - {23'h000000, tape_byte};

   // Tape side progress, in bytes and blocks
   if (tape_byte && active) begin
      if (s_q.fixed && s_q.byte_tape_blk == s_q.blk_len - 24'h000001) begin
         s_d.byte_tape_blk = 24'h000000;
         s_d.blks_tape = s_q.blks_tape + 24'h000001;
      end else begin
         s_d.byte_tape_blk = s_q.byte_tape_blk + 24'h000001;
      end
   end

   // Read-back verdict per physical block
   if (pblk_done) begin
      if (pblk_ok) begin
         if (s_q.retry == 4'h0) begin
            s_d.consec = 5'h00;
         end
         s_d.retry = 4'h0;
      end else begin
         s_d.rewrite = 1'b1;
         s_d.retry = s_q.retry + 4'h1;
         if (s_q.retry == 4'h0) begin
            s_d.consec = s_q.consec + 5'h01;
         end
      end
   end
   if (retry_out || consec_out) begin
      s_d.retry = 4'h0;
      s_d.consec = 5'h00;
   end

   // Clear first, so a write arriving together still sets it
   if (leave_write) begin
      s_d.wmode = 1'b0;
   end

   case (s_q.phase)
      PH_IDLE: begin
         if (is_write) begin
            s_d.sense = '0;
            if (err_nr) begin
               s_d.stat_v = 1'b1;
               s_d.check = 1'b1;
               s_d.sense.key = KEY_NOT_READY;
            end else if (err_wp) begin
               s_d.stat_v = 1'b1;
               s_d.check = 1'b1;
               s_d.sense.key = KEY_PROTECT;
               s_d.sense.wp = 1'b1;
            end else if (err_pos || err_mode || err_lim || err_nd) begin
               s_d.stat_v = 1'b1;
               s_d.check = 1'b1;
               s_d.sense.key = KEY_ILLEGAL;
            end else begin
               s_d.wmode = 1'b1;
               s_d.fixed = fixed_req;
               s_d.buffered = cfg.buffered;
               s_d.logical_end_warning_hold = 1'b0;
               s_d.len = req_len;
               s_d.blk_len = fixed_req ? cfg.block_size : req_len;
               s_d.nblk = fixed_req ? req_len : 24'h000001;
               s_d.byte_in_blk = 24'h000000;
               s_d.blks_in = 24'h000000;
               s_d.byte_tape_blk = 24'h000000;
               s_d.blks_tape = 24'h000000;
               if (req_len == 24'h000000) begin
                  s_d.stat_v = 1'b1;
                  s_d.check = 1'b0;
               end else begin
                  s_d.phase = PH_XFER;
               end
            end
         end
      end
      PH_XFER: begin
         if (media.logical_end_warning) begin
            s_d.buffered = 1'b0;
            s_d.logical_end_warning_hold = 1'b1;
         end
         if (blk_end_in) begin
            s_d.byte_in_blk = 24'h000000;
            s_d.blks_in = s_q.blks_in + 24'h000001;
            // Stop at the block boundary once the warning is seen
            if (s_d.blks_in == s_q.nblk || s_d.logical_end_warning_hold) begin
               s_d.phase = PH_WAIT;
            end
         end else if (take) begin
            s_d.byte_in_blk = s_q.byte_in_blk + 24'h000001;
         end
      end
      PH_WAIT: begin
         if (media.logical_end_warning) begin
            s_d.buffered = 1'b0;
            s_d.logical_end_warning_hold = 1'b1;
         end
         if (s_d.buffered) begin
            s_d.stat_v = 1'b1;
            s_d.check = 1'b0;
            s_d.phase = PH_IDLE;
         end else if (s_q.level == 24'h000000) begin
            s_d.stat_v = 1'b1;
            s_d.check = s_d.logical_end_warning_hold;
            s_d.sense = '0;
            s_d.sense.end_of_medium_flag = s_d.logical_end_warning_hold;
            s_d.sense.valid = s_d.logical_end_warning_hold && s_q.fixed;
            s_d.sense.key = KEY_NO_SENSE;
            s_d.sense.info = (s_d.logical_end_warning_hold && s_q.fixed) ? info_diff
               : 24'h000000;
            s_d.phase = PH_IDLE;
         end
      end
      default: begin
         s_d.phase = PH_IDLE;
      end
   endcase

   // Aborts override normal completion
   if (active) begin
      if (media.physical_end_of_tape) begin
         s_d.stat_v = 1'b1;
         s_d.check = 1'b1;
         s_d.sense = '0;
         s_d.sense.valid = 1'b1;
         s_d.sense.end_of_medium_flag = 1'b1;
         s_d.sense.physical_end_of_tape = 1'b1;
         s_d.sense.key = s_q.level != 24'h000000 ? KEY_OVERFLOW : KEY_NO_SENSE;
         s_d.sense.info = (s_q.level != 24'h000000 || !s_q.fixed) ? info_diff
            : 24'h000000;
         s_d.phase = PH_IDLE;
      end else if (retry_out || consec_out) begin
         s_d.stat_v = 1'b1;
         s_d.check = 1'b1;
         s_d.sense = '0;
         s_d.sense.valid = 1'b1;
         s_d.sense.med_err = 1'b1;
         s_d.sense.retry_exh = retry_out;
         s_d.sense.key = KEY_MEDIUM;
         s_d.sense.info = info_diff;
         s_d.phase = PH_IDLE;
      end
   end

   // Motion: hold below threshold while buffered, then empty it
   if (s_q.level == 24'h000000) begin
      s_d.drain = 1'b0;
   end else if (!s_q.buffered || s_q.level >= motion_thr) begin
      s_d.drain = 1'b1;
   end

   // Full buffer stops the host until space reaches the threshold
   if (s_d.level >= BUF_CAP_BYTES) begin
      s_d.disc = 1'b1;
   end else if (s_q.disc && BUF_CAP_BYTES - s_d.level >= cfg.reconn_thr) begin
      s_d.disc = 1'b0;
   end
   s_d.take_en = s_d.phase == PH_XFER && !s_d.disc;

   // Button stays locked until write mode ends and tape holds all
   if (s_d.wmode && s_d.level != 24'h000000) begin
      s_d.btn_en = 1'b0;
   end else if (!s_d.wmode && s_d.level == 24'h000000) begin
      s_d.btn_en = 1'b1;
   end
end

always_ff @(posedge core_clk or negedge rst_b) begin
   if (!rst_b) begin
      s_q <= STATE_RESET;
   end else begin
      s_q <= s_d;
   end
end

// ==========================================================
// Outputs
assign xfer_active = s_q.take_en;
assign tape_go = s_q.drain;
assign rewrite_req = s_q.rewrite;
assign disconnect = s_q.disc;
assign write_mode = s_q.wmode;
assign button_enable = s_q.btn_en;
assign status_valid = s_q.stat_v;
assign status_check = s_q.check;
assign sense = s_q.sense;

// ==========================================================
// Checks
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!rst_b);

sequence clean_cmd_s;
   is_write && !err_nr && !err_wp && !err_pos && !err_mode && !err_lim && !err_nd;
endsequence

sequence fail_s;
   active && pblk_done && !pblk_ok;
endsequence

zero_len_good_a: assert property (clean_cmd_s and req_len == 24'h000000
   |=> status_valid && !status_check && write_mode)
   else $error("zero length write not completed good");

not_ready_a: assert property (is_write && err_nr
   |=> status_valid && status_check && sense.key == KEY_NOT_READY)
   else $error("not ready key missing");

protect_key_a: assert property (is_write && !err_nr && err_wp
   |=> status_check && sense.key == KEY_PROTECT && sense.wp)
   else $error("write protect not reported");

bad_position_a: assert property (is_write && !err_nr && !err_wp && err_pos
   |=> status_check && sense.key == KEY_ILLEGAL && !$rose(write_mode))
   else $error("bad position accepted");

retry_limit_a: assert property (fail_s and s_q.retry == RETRY_LIMIT - 4'h1
   and !media.physical_end_of_tape |=> status_valid && sense.retry_exh
   && sense.med_err && sense.key == KEY_MEDIUM)
   else $error("retry limit not reported");

consec_fail_a: assert property (fail_s and s_q.retry == 4'h0
   and s_q.consec == CONSEC_LIMIT - 5'h01 and !media.physical_end_of_tape
   |=> status_valid && sense.med_err && !sense.retry_exh && sense.valid)
   else $error("consecutive failures not reported");

rewrite_pulse_a: assert property (pblk_done && !pblk_ok
   |=> rewrite_req ##1 !rewrite_req || (pblk_done && !pblk_ok))
   else $error("rewrite request missing");

full_disc_a: assert property (s_q.level >= BUF_CAP_BYTES
   |-> disconnect && !xfer_active)
   else $error("full buffer still connected");

motion_hold_a: assert property ($rose(tape_go) && $past(s_q.buffered)
   |-> $past(s_q.level) >= $past(motion_thr))
   else $error("tape started below motion threshold");

nonbuf_good_a: assert property ($rose(status_valid) && !status_check
   && $past(s_q.phase) == PH_WAIT && !$past(s_q.buffered)
   |-> $past(s_q.level) == 24'h000000)
   else $error("good status before tape empty");

button_lock_a: assert property (write_mode && s_q.level != 24'h000000
   |-> !button_enable)
   else $error("button enabled with buffered data");

endmodule
